/* verilog/pia_params.svh */
// constants for the priority interrupt address generator
// assumes a 50 MHz cpu clock and a 64-point lower half
`ifndef PIA_PARAMS_SVH
`define PIA_PARAMS_SVH
`define PIA_POINTS       64
`define PIA_GROUPS4      16
`define PIA_MASK_W       32
`define PIA_MASK_HALF_W  16
`define PIA_MASK_RESET   32'hFFFFFFFF
`define PIA_SETTLE_CLKS  3
`define PIA_ADDR_BASE    8'h80
`define PIA_KEY_AUTO     2'h1
`define PIA_KEY_MANUAL   2'h2
`endif

/* verilog/pia_pkg.sv */
// types for the priority interrupt address generator
// constants live in pia_params.svh
package pia_pkg;
  typedef enum logic [1:0] {
    PIA_IDLE   = 2'b00,
    PIA_SETTLE = 2'b01,
    PIA_READY  = 2'b11,
    PIA_FETCH  = 2'b10
  } pia_state_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } pia_resp_t;
endpackage : pia_pkg

/* verilog/pia_addr_gen.sv */
// priority interrupt logic: change detectors, pending and priority flops,
// group mask, console lockout, response address generation, test commands
// assumes the cpu sequence control drives the command strobes synchronously
// assumes interrupt lines idle high and are pulled low to interrupt
`timescale 1ns/100ps
`include "pia_params.svh"
module pia_addr_gen (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [`PIA_POINTS-1:0]        irq_line,
  input  wire logic [`PIA_POINTS-1:0]        irq_inhibitable,
  input  wire logic [1:0]                    console_key,
  input  wire logic                          lockout_sw,
  input  wire logic                          inhibit_auto_irq_instr,
  input  wire logic                          permit_auto_irq_instr,
  input  wire logic                          mask_load_low_cmd,
  input  wire logic                          mask_load_high_cmd,
  input  wire logic [23:0]                   accumulator,
  input  wire logic                          test_cmd,
  input  wire logic [2:0]                    test_card,
  input  wire logic [7:0]                    test_pattern,
  input  wire logic                          instr_interruptable,
  input  wire logic                          instr_done,
  input  wire logic                          resp_fetch,
  output pia_pkg::pia_resp_t                 resp_q,
  output logic                               mem_addr_from_irq_q,
  output logic                               no_irq_present_n_q,
  output logic                               permit_q,
  output logic [`PIA_POINTS-1:0]             line_pending_q
);
  localparam int NPT = `PIA_POINTS;
  localparam int NG4 = `PIA_GROUPS4;

  // two-flop synchronisers on outside signals; stage two is read, and the line edge detector also reads stage three
  logic [NPT-1:0] line_s1_q, line_s2_q, line_s3_q;
  logic [1:0]     key_s1_q, key_s2_q;
  logic           lock_s1_q, lock_s2_q;

  // lines reset to their idle high level, so the release of reset makes no false edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_s1_q <= '1;
      line_s2_q <= '1;
      line_s3_q <= '1;
    end else begin
      line_s1_q <= irq_line;
      line_s2_q <= line_s1_q;
      line_s3_q <= line_s2_q; // stage three only remembers the last settled level
    end
  end

  // console switches are slow levels; two stages cost little and settle them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key_s1_q  <= 2'h0;
      key_s2_q  <= 2'h0;
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
    end else begin
      key_s1_q  <= console_key;
      key_s2_q  <= key_s1_q;
      lock_s1_q <= lockout_sw;
      lock_s2_q <= lock_s1_q;
    end
  end

  // lockout honoured only in auto or manual key positions
  logic lockout;
  assign lockout = lock_s2_q && (key_s2_q == `PIA_KEY_AUTO || key_s2_q == `PIA_KEY_MANUAL);

  // falling edge of a line is the change-detector spike
  logic [NPT-1:0] edge_det;
  assign edge_det = line_s3_q & ~line_s2_q;

  // test commands inject a simulated edge on one eight-point card
  logic [NPT-1:0] test_hit;
  always_comb begin
    test_hit = '0;
    if (test_cmd) begin
      test_hit[test_card*8 +: 8] = test_pattern;
    end
  end

  // mask register: reset inhibits all groups until software loads it
  // the upper half is kept for software but has no points behind it in this build
  logic [`PIA_MASK_W-1:0] mask_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= `PIA_MASK_RESET;
    end else begin
      if (mask_load_low_cmd) begin
        mask_q[`PIA_MASK_HALF_W-1:0] <= accumulator[`PIA_MASK_HALF_W-1:0];
      end
      if (mask_load_high_cmd) begin
        mask_q[`PIA_MASK_W-1:`PIA_MASK_HALF_W] <= accumulator[`PIA_MASK_HALF_W-1:0];
      end
    end
  end

  // permit flop: inhibit instruction clears, permit instruction sets
  // a coincident permit and inhibit leaves the flop set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      permit_q <= 1'b0;
    end else if (permit_auto_irq_instr) begin
      permit_q <= 1'b1;
    end else if (inhibit_auto_irq_instr) begin
      permit_q <= 1'b0;
    end
  end

  pia_pkg::pia_state_t state_q;
  logic [1:0]          settle_q;
  logic [5:0]          win_idx_q;
  logic                after_irq_q;
  logic [NPT-1:0]      prio_q;
  logic [NPT-1:0]      clr_pt;

  // pending flops: set wins over clear so a coincident edge is kept
  // lockout does not reach here, so lines are remembered while service is held
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_pending_q <= '0;
    end else begin
      line_pending_q <= (line_pending_q & ~clr_pt) | edge_det | test_hit;
    end
  end

  // priority flops load only while no request is being addressed
  // frozen otherwise, so a later, higher arrival cannot displace the address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prio_q <= '0;
    end else if (no_irq_present_n_q) begin
      prio_q <= line_pending_q & ~clr_pt;
    end else begin
      prio_q <= prio_q & ~clr_pt;
    end
  end

  // a point may be serviced if unmasked and, if inhibitable, permitted
  logic [NPT-1:0] eligible;
  logic [NG4-1:0] g4_act, grant;
  logic [1:0]     ident [NG4];
  genvar gi;
  generate
    for (gi = 0; gi < NG4; gi++) begin : g_four
      logic [3:0] p;
      assign p = prio_q[gi*4 +: 4] & eligible[gi*4 +: 4];
      assign g4_act[gi] = (|p) && !mask_q[gi];
      // lowest-numbered set flop is the highest priority
      assign ident[gi] = p[0] ? 2'd0 : p[1] ? 2'd1 : p[2] ? 2'd2 : 2'd3;
    end
    // non-inhibitable points ignore the permit flop
    for (gi = 0; gi < NPT; gi++) begin : g_elig
      assign eligible[gi] = permit_q || !irq_inhibitable[gi];
    end
  endgenerate

  // half-card grants within each sixteen; group priority across groups
  logic [3:0] grp_req, grp_prio;
  logic       lower_request_gate;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sixteen
      assign grant[gi*4]   = g4_act[gi*4];
      assign grant[gi*4+1] = g4_act[gi*4+1] && !g4_act[gi*4];
      assign grant[gi*4+2] = g4_act[gi*4+2] && !(|g4_act[gi*4 +: 2]);
      assign grant[gi*4+3] = g4_act[gi*4+3] && !(|g4_act[gi*4 +: 3]);
      assign grp_req[gi]   = |grant[gi*4 +: 4];
    end
  endgenerate
  // the first group needs no gate: nothing outranks it
  assign grp_prio[0] = grp_req[0];
  assign grp_prio[1] = grp_req[1] && !grp_req[0];
  assign grp_prio[2] = grp_req[2] && !(|grp_req[1:0]);
  assign grp_prio[3] = grp_req[3] && !(|grp_req[2:0]);
  // the lower request alone starts the settle count
  assign lower_request_gate = |grp_req;

  // winning half-card index; bits 2..5 follow area and half
  logic [3:0] win_g4;
  logic [7:0] addr_form;
  always_comb begin
    win_g4 = 4'h0;
    for (int k = NG4 - 1; k >= 0; k--) begin
      if (grant[k] && grp_prio[k/4]) begin
        win_g4 = 4'(k);
      end
    end
    // point index under the fixed base; bit 6 would mark the upper points
    addr_form    = `PIA_ADDR_BASE;
    addr_form[1:0] = ident[win_g4];
    addr_form[2] = win_g4[0];
    addr_form[3] = win_g4[1];
    addr_form[4] = grp_prio[1] || grp_prio[3];
    addr_form[5] = grp_prio[2] || grp_prio[3];
    addr_form[6] = 1'b0;
  end

  // clear only the fetched point's flops
  // the index is latched at presentation, so a later arrival cannot redirect it
  always_comb begin
    clr_pt = '0;
    if (state_q == pia_pkg::PIA_READY && resp_fetch) begin
      clr_pt[win_idx_q] = 1'b1;
    end
  end

  // sequence: request, three-clock settle, present, fetch, one instruction gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q             <= pia_pkg::PIA_IDLE;
      settle_q            <= 2'h0;
      win_idx_q           <= 6'h0;
      resp_q              <= '0;
      mem_addr_from_irq_q <= 1'b0;
      no_irq_present_n_q  <= 1'b1;
    end else begin
      case (state_q)
        // idle: wait for any granted group
        pia_pkg::PIA_IDLE: begin
          resp_q.valid        <= 1'b0;
          mem_addr_from_irq_q <= 1'b0;
          if (lower_request_gate) begin
            no_irq_present_n_q <= 1'b0;
            settle_q           <= 2'h1;
            state_q            <= pia_pkg::PIA_SETTLE;
          end
        end

        // settle: count out the timer, then offer the address when allowed
        pia_pkg::PIA_SETTLE: begin
          if (settle_q == 2'(`PIA_SETTLE_CLKS)) begin
            win_idx_q <= {win_g4, addr_form[1:0]};
            resp_q.addr <= addr_form;
            // lockout and the one-instruction gap hold service off
            if (!lockout && instr_done && instr_interruptable && !after_irq_q) begin
              resp_q.valid        <= 1'b1;
              mem_addr_from_irq_q <= 1'b1;
              state_q             <= pia_pkg::PIA_READY;
            end
          end else begin
            settle_q <= settle_q + 2'h1;
          end
          if (!lower_request_gate) begin
            no_irq_present_n_q <= 1'b1;
            state_q            <= pia_pkg::PIA_IDLE;
          end
        end

        // ready: the address stands until the processor fetches it
        pia_pkg::PIA_READY: begin
          if (resp_fetch) begin
            resp_q.valid        <= 1'b0;
            mem_addr_from_irq_q <= 1'b0;
            state_q             <= pia_pkg::PIA_FETCH;
          end
        end

        // fetch: the point's flops cleared on entry; free the priority flops next
        pia_pkg::PIA_FETCH: begin
          no_irq_present_n_q <= 1'b1;
          state_q            <= pia_pkg::PIA_IDLE;
        end
        default: begin
          state_q <= pia_pkg::PIA_IDLE;
        end
      endcase
    end
  end

  // one-instruction gap: set by the fetch, cleared by a later completion in any state,
  // so a request already waiting in settle cannot hang on a stale gap; set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      after_irq_q <= 1'b0;
    end else if (state_q == pia_pkg::PIA_READY && resp_fetch) begin
      after_irq_q <= 1'b1;
    end else if (instr_done) begin
      after_irq_q <= 1'b0;
    end
  end
endmodule : pia_addr_gen

/* tb/pia_addr_gen_asserts.sv */
// checker for pia_addr_gen: response hold, fetch clear, settle and lockout
// bound to pia_addr_gen below; sees its ports only
`timescale 1ns/100ps
`include "pia_params.svh"
module pia_addr_gen_asserts (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic [1:0]             console_key,
  input wire logic                   lockout_sw,
  input wire logic                   permit_auto_irq_instr,
  input wire logic                   resp_fetch,
  input wire pia_pkg::pia_resp_t     resp_q,
  input wire logic                   no_irq_present_n_q,
  input wire logic                   permit_q,
  input wire logic [`PIA_POINTS-1:0] line_pending_q
);
  logic [5:0] pt_q;
  wire        lock = lockout_sw && console_key inside {`PIA_KEY_AUTO, `PIA_KEY_MANUAL};
  // point on show at each edge, so its clear is judged one cycle after the fetch
  always_ff @(posedge clk) pt_q <= resp_q.addr[5:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_addr_top: assert property (resp_q.valid |-> resp_q.addr[7:6] == 2'h2)
    else $error("address top bits wrong");
  a_addr_hold: assert property (resp_q.valid && !resp_fetch |=> resp_q.valid && $stable(resp_q.addr))
    else $error("address moved before fetch");
  a_fetch_gap: assert property (resp_q.valid && resp_fetch |=> !resp_q.valid [*4])
    else $error("response not dropped at fetch");
  a_fetch_clear: assert property (resp_q.valid && resp_fetch |=> !line_pending_q[pt_q])
    else $error("fetched point still pending");
  a_settle_wait: assert property ($rose(resp_q.valid) |-> !$past(no_irq_present_n_q, 3))
    else $error("address shown before settle");
  a_nip_low: assert property (resp_q.valid |-> !no_irq_present_n_q)
    else $error("no-irq flag high while serving");
  a_lock_hold: assert property ($rose(resp_q.valid) |-> !$past(lock, 3))
    else $error("service while locked out");
  a_permit_set: assert property ($rose(permit_q) |-> $past(permit_auto_irq_instr))
    else $error("permit set without command");
  c_serve: cover property (resp_q.valid && resp_fetch);
  c_lock: cover property (lock && |line_pending_q);
  c_inhibit: cover property ($fell(permit_q));
endmodule : pia_addr_gen_asserts

bind pia_addr_gen pia_addr_gen_asserts pia_addr_gen_asserts_i (.*);

/* tb/pia_cpu_model.sv */
// cpu model: ends an instruction every other cycle, fetches each response
// assumes resp_q stands until fetched; slow delays the fetch
`timescale 1ns/100ps
module pia_cpu_model (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               slow,
  input wire pia_pkg::pia_resp_t resp_q,
  output logic                   instr_done,
  output logic                   instr_interruptable,
  output logic                   resp_fetch
);
  logic [2:0] wait_q;
  // one fetch per response, never back to back, so no response is taken twice
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {instr_done, instr_interruptable, resp_fetch, wait_q} <= 6'h0;
    end else begin
      instr_done          <= !instr_done;
      instr_interruptable <= !slow || (instr_interruptable ^ instr_done); // slow: every other instruction
      wait_q              <= resp_q.valid ? wait_q - {2'h0, |wait_q} : {3{slow}};
      resp_fetch          <= resp_q.valid && !resp_fetch && !wait_q;
    end
  end
endmodule : pia_cpu_model

/* tb/pia_addr_gen_tb_top.sv */
// bench for pia_addr_gen with a cpu model fetching each response
// assumes lines idle high; a falling edge interrupts
`timescale 1ns/100ps
`include "pia_params.svh"
module pia_addr_gen_tb_top;
  logic                   clk, slow = 1'b0, rst_b = 1'b0, lockout_sw = 1'b0;
  logic                   instr_done, instr_interruptable, resp_fetch;
  logic                   mem_addr_from_irq_q, no_irq_present_n_q, permit_q;
  logic [`PIA_POINTS-1:0] irq_line = ~64'h0, irq_inhibitable = 64'h0, line_pending_q;
  logic [1:0]             console_key = 2'h0;
  logic [4:0]             cmd = 5'h0;
  logic [23:0]            accumulator = 24'h0;
  logic [2:0]             test_card = 3'h0;
  logic [7:0]             test_pattern = 8'h0;
  pia_pkg::pia_resp_t     resp_q;
  int                     err_count, checks_done, k, p, q;

  pia_addr_gen pia_addr_gen_i (.inhibit_auto_irq_instr(cmd[0]), .mask_load_low_cmd(cmd[1]),
    .mask_load_high_cmd(cmd[2]), .permit_auto_irq_instr(cmd[3]), .test_cmd(cmd[4]), .*);
  pia_cpu_model pia_cpu_model_i (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] exp_addr(int n);
    return 8'h80 | n[7:0];
  endfunction : exp_addr

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // one command pulse and a set of falling lines, then lines back to idle
  task automatic act(logic [4:0] c, logic [23:0] a, logic [63:0] m);
    @(posedge clk);
    cmd         <= c;
    accumulator <= a;
    irq_line    <= ~m;
    @(posedge clk);
    cmd <= 5'h0;
    repeat (3) @(posedge clk);
    irq_line <= ~64'h0;
  endtask : act

  // n below zero: no fetch may come within lim cycles
  task automatic serve(int n, int lim = 400);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk);
      if (resp_fetch && resp_q.valid) break;
    end
    chk("fetch", n < 0 ? 64'h0 : {55'h0, 1'b1, exp_addr(n)},
        i < lim ? {55'h0, mem_addr_from_irq_q, resp_q.addr} : 64'h0);
    if (i == lim && n >= 0) tally_and_finish();
  endtask : serve

  // mask, permit, random pairs, lockout per key, then test commands
  initial begin
    p = $urandom(97);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    act(5'h0, 24'h0, 64'h1);
    serve(-1, 30);
    chk("pending", 64'h1, line_pending_q);
    act(5'h4, 24'h0, 64'h0);
    act(5'h2, 24'hFF0200, 64'h0);
    serve(0);
    act(5'h0, 24'h0, 64'h13000000000);
    serve(40);
    serve(-1, 20);
    chk("pending", 64'h3000000000, line_pending_q);
    act(5'h2, 24'h0, 64'h0);
    serve(36);
    serve(37);
    irq_inhibitable <= 64'h20;
    act(5'h8, 24'h0, 64'h0);
    act(5'h1, 24'h0, 64'h20);
    chk("permit", 64'h0, {63'h0, permit_q});
    serve(-1, 20);
    act(5'h8, 24'h0, 64'h0);
    serve(5);
    for (k = 0; k < 10; k++) begin
      p = k ? $urandom % 64 : 63;
      q = k ? $urandom % 64 : 0;
      slow <= k[0];
      irq_inhibitable <= {$urandom, $urandom};
      act(5'h0, 24'h0, (64'h1 << p) | (64'h1 << q));
      serve(p < q ? p : q);
      if (p != q) serve(p < q ? q : p);
    end
    for (k = 0; k < 4; k++) begin
      console_key <= k[1:0];
      lockout_sw  <= 1'b1;
      act(5'h0, 24'h0, 64'h100 << k);
      if (k == 1 || k == 2) begin
        act(5'h0, 24'h0, 64'h100 << k);
        serve(-1, 20);
        lockout_sw <= 1'b0;
      end
      serve(8 + k);
      serve(-1, 30);
    end
    lockout_sw <= 1'b0;
    for (k = 0; k < 8; k++) begin
      q = $urandom % 8;
      test_card    <= k[2:0];
      test_pattern <= 8'h1 << q;
      act(5'h10, 24'h0, 64'h0);
      serve(8 * k + q);
    end
    tally_and_finish();
  end
endmodule : pia_addr_gen_tb_top
